// [core/periph_gate.sv]
// Purpose: Reset and clock gate for one peripheral block.
// Assumes: Write strobe already decoded for this block.
// Notes:   Clock also drops while the fast oscillator is off.
`timescale 1ns/10ps
`include "pm_defines.svh"
`default_nettype none
module periph_gate (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Control word write
  input wire logic wr_en,
  input wire logic [1:0] wdata,
  input wire logic clear,
  input wire logic osc_on,
  // Access path
  input wire logic acc_req,
  output logic acc_ok,
  // Gate outputs
  output logic [1:0] ctl_bits,
  output logic clk_en,
  output logic rst_n
);

  logic run_ok; // Block fully usable

  //////////////////////////////////////////////////////////////////////
  // Software bits, both 0 after reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_bits <= `PM_PERIPH_RST;
    end else if (clear) begin
      ctl_bits <= `PM_PERIPH_RST;
    end else if (wr_en) begin
      ctl_bits <= wdata;
    end
  end

  // Usable only with clock on and reset released
  assign run_ok = ctl_bits[`PM_PB_ENABLE] & ctl_bits[`PM_PB_RESETN] & osc_on;
  //////////////////////////////////////////////////////////////////////
  // Registered gate outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clk_en <= 1'b0;
      rst_n <= 1'b0;
      acc_ok <= 1'b0;
    end else begin
      clk_en <= ctl_bits[`PM_PB_ENABLE] & osc_on;
      rst_n <= ctl_bits[`PM_PB_RESETN] & ~clear;
      acc_ok <= acc_req & run_ok & ~clear;
    end
  end

endmodule // periph_gate
`default_nettype wire

// [core/pm_defines.svh]
// Purpose: Offsets, field positions, reset values and timing counts
//          for the power-mode and peripheral clock controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Functional notes below list the behaviour in short form.
//
// Functional notes
// - Power-up lands in active, everything running; peripheral blocks start clock-gated and in reset
// - Wait instruction idles CPU; any interrupt wakes
// - Deep sleep: fast osc off, CPU reset
// - Shutdown bit: all off, registers reset; wake-allow and wake-cause bits are kept
// - High pin wakes if its allow bit set
// - Deep sleep: low pin wakes if allowed
// - Power down: low pin always wakes
// - Sequencer runs only in active or sleep
// - Each peripheral has reset and clock bits
// - Clearing clock bit stops that peripheral clock
// - No peripheral access while gated or reset
// - Peripheral bits reset to 0, run at 1
// - Deep sleep countdown wakes if nonzero start
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH

// Register port
`define PM_ADDR_W 8
`define PM_DATA_W 32

// Peripheral control words
`define PM_OFS_GPIO 8'h20
`define PM_OFS_I2CM 8'h2c
`define PM_OFS_I2CS 8'h30
`define PM_OFS_UART 8'h34
`define PM_OFS_TMR 8'h38
`define PM_OFS_AFE 8'h3c
`define PM_NUM_PERIPH 6
`define PM_PB_RESETN 0
`define PM_PB_ENABLE 1
`define PM_PERIPH_RST 2'h0

// Low power configuration
`define PM_OFS_SLEEP_CNT 8'h60
`define PM_SLEEP_CNT_W 16
`define PM_SLEEP_CNT_RST 16'h0000

// Mode control word
`define PM_OFS_CTRL 8'h64
`define PM_CB_SHUTDOWN 0
`define PM_CB_DEEP 1
`define PM_CB_HI_ALLOW 2
`define PM_CB_LO_ALLOW 3

// Status word
`define PM_OFS_STAT 8'h68
`define PM_SB_MODE 0
`define PM_SB_CAUSE 4

// Timing
`define PM_CLK_NS 10
`define PM_SLOW_TICK_NS 1953125
`define PM_SLOW_DIV (`PM_SLOW_TICK_NS / `PM_CLK_NS)
`define PM_SLOW_DIV_W 18
`define PM_OSC_START_NS 1000
`define PM_OSC_START_CYC ((`PM_OSC_START_NS + `PM_CLK_NS - 1) / `PM_CLK_NS)
`define PM_OSC_CNT_W 8

`endif

// [core/pm_pkg.sv]
// Purpose: Types shared by the power-mode controller files.
// Assumes: Compiled before all design modules.
// Notes:   Sequencer states step by one bit from power down through the wake states.
package pm_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h0,
    ST_DEEP = 3'h1,
    ST_PDOWN = 3'h3,
    ST_WAKE_OSC = 3'h2,
    ST_WAKE_REL = 3'h6,
    ST_SLEEP = 3'h4
  } pm_state_t;

  // Mode reported to the outside
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_DEEP = 2'h2,
    MODE_PDOWN = 2'h3
  } pm_mode_t;

endpackage

// [core/power_mode_ctrl.sv]
// Purpose: Operating mode sequencer, wake logic and peripheral
//          clock unit for a sensing device with an embedded CPU.
// Assumes: mclk is always running; the slow tick is derived here.
// Notes:   Mode-dependent supplies are driven out as enables.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "pm_defines.svh"
`default_nettype none
module power_mode_ctrl #(
  parameter int unsigned SLOW_DIV = `PM_SLOW_DIV
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic [`PM_ADDR_W-1:0] reg_addr,
  input wire logic [`PM_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`PM_DATA_W-1:0] reg_rdata,
  // Processor events
  input wire logic wait_interrupt_instruction,
  input wire logic irq_any,
  // Wake pins
  input wire logic high_active_wake_pin,
  input wire logic low_active_wake_pin,
  // Supply, oscillator and CPU control
  output logic core_regulator_on,
  output logic fast_osc_on,
  output logic slow_osc_on,
  output logic cpu_rst_n,
  output logic cpu_idle,
  output logic seq_run_en,
  output pm_pkg::pm_mode_t mode,
  // Peripheral clock unit
  input wire logic [`PM_NUM_PERIPH-1:0] periph_acc_req,
  output logic [`PM_NUM_PERIPH-1:0] periph_acc_ok,
  output logic [`PM_NUM_PERIPH-1:0] periph_clk_en,
  output logic [`PM_NUM_PERIPH-1:0] periph_rst_n
);
  import pm_pkg::*;

  localparam int unsigned NP = `PM_NUM_PERIPH;

  //////////////////////////////////////////////////////////////////////
  // Address decode of the peripheral words, shared by write and read
  function automatic logic [3:0] periph_dec(
    input logic [`PM_ADDR_W-1:0] a
  );
    case (a)
      `PM_OFS_GPIO: periph_dec = 4'h8;
      `PM_OFS_I2CM: periph_dec = 4'h9;
      `PM_OFS_I2CS: periph_dec = 4'ha;
      `PM_OFS_UART: periph_dec = 4'hb;
      `PM_OFS_TMR: periph_dec = 4'hc;
      `PM_OFS_AFE: periph_dec = 4'hd;
      default: periph_dec = 4'h0;
    endcase
  endfunction

  pm_state_t state_q; // Current mode state
  pm_state_t state_d; // Next mode state
  logic [1:0] pin_s; // Synced pins, {high, low}
  logic hi_lvl; // High-active pin asserted
  logic lo_lvl; // Low-active pin asserted (pin low)
  logic [`PM_SLOW_DIV_W-1:0] div_q; // Slow tick divider
  logic tick_q; // One pulse per slow period
  logic shutdown_q; // Power down request
  logic deep_req_q; // Next wait goes to deep sleep
  logic hi_allow_q; // high_pin_wake_allow
  logic lo_allow_q; // low_pin_wake_allow
  logic [`PM_SLEEP_CNT_W-1:0] sleep_start_q; // Countdown start
  logic [`PM_SLEEP_CNT_W-1:0] cnt_q; // Running countdown
  logic armed_q; // Countdown loaded nonzero
  logic cnt_done; // Countdown expired
  logic [`PM_OSC_CNT_W-1:0] osc_cnt_q; // Oscillator settle count
  logic [2:0] cause_q; // Sticky wake causes {cnt, lo, hi}
  logic pd_clear; // Register clear in power down
  logic reg_wen; // Write accepted
  logic [3:0] wdec; // Write decode {hit, idx}
  logic [3:0] rdec; // Read decode {hit, idx}
  logic [2*NP-1:0] pbits; // Peripheral control bits
  logic [`PM_DATA_W-1:0] rd_val; // Read mux value
  logic wake_deep; // Deep sleep exit
  logic wake_pd; // Power down exit

  //////////////////////////////////////////////////////////////////////
  // Wake pins pass two flops before use; low pin idles high
  wake_sync #(
    .W(2),
    .RST(2'h1)
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .din({high_active_wake_pin, low_active_wake_pin}),
    .dout(pin_s)
  );

  assign hi_lvl = pin_s[1];
  assign lo_lvl = ~pin_s[0];

  //////////////////////////////////////////////////////////////////////
  // Slow tick; stops with the slow oscillator in power down
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (state_q == ST_PDOWN) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == `PM_SLOW_DIV_W'(SLOW_DIV - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register writes; only a running CPU can write
  assign reg_wen = reg_wr & cpu_rst_n;
  assign wdec = periph_dec(reg_addr);
  assign rdec = periph_dec(reg_addr);
  // Everything but the wake-allow and wake-cause bits clears in power down
  assign pd_clear = (state_d == ST_PDOWN);

  // Mode control word
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shutdown_q <= 1'b0;
      deep_req_q <= 1'b0;
    end else if (pd_clear) begin
      shutdown_q <= 1'b0;
      deep_req_q <= 1'b0;
    end else if (state_q == ST_WAKE_REL) begin
      // Deep request is consumed by the wake
      deep_req_q <= 1'b0;
    end else if (reg_wen && reg_addr == `PM_OFS_CTRL) begin
      shutdown_q <= reg_wdata[`PM_CB_SHUTDOWN];
      deep_req_q <= reg_wdata[`PM_CB_DEEP];
    end
  end

  // Allow bits sit in the always-on domain so a pin can still wake
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hi_allow_q <= 1'b0;
      lo_allow_q <= 1'b0;
    end else if (reg_wen && reg_addr == `PM_OFS_CTRL) begin
      hi_allow_q <= reg_wdata[`PM_CB_HI_ALLOW];
      lo_allow_q <= reg_wdata[`PM_CB_LO_ALLOW];
    end
  end

  // Countdown start value
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_start_q <= `PM_SLEEP_CNT_RST;
    end else if (pd_clear) begin
      sleep_start_q <= `PM_SLEEP_CNT_RST;
    end else if (reg_wen && reg_addr == `PM_OFS_SLEEP_CNT) begin
      sleep_start_q <= reg_wdata[`PM_SLEEP_CNT_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Peripheral gates, one per block
  for (genvar i = 0; i < NP; i++) begin : g_periph
    periph_gate u_gate (
      .mclk(mclk),
      .arst_n(arst_n),
      .wr_en(reg_wen && wdec == {1'b1, 3'(i)}),
      .wdata(reg_wdata[1:0]),
      .clear(pd_clear),
      .osc_on(fast_osc_on),
      .acc_req(periph_acc_req[i]),
      .acc_ok(periph_acc_ok[i]),
      .ctl_bits(pbits[2*i +: 2]),
      .clk_en(periph_clk_en[i]),
      .rst_n(periph_rst_n[i])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // Deep sleep countdown in slow ticks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      armed_q <= 1'b0;
    end else if (state_q != ST_DEEP && state_d == ST_DEEP) begin
      cnt_q <= sleep_start_q;
      armed_q <= (sleep_start_q != '0);
    end else if (state_q != ST_DEEP) begin
      armed_q <= 1'b0;
    end else if (tick_q && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign cnt_done = armed_q & (cnt_q == '0);

  //////////////////////////////////////////////////////////////////////
  // Wake conditions
  assign wake_deep = (hi_lvl & hi_allow_q)
                   | (lo_lvl & lo_allow_q)
                   | cnt_done;
  assign wake_pd = (hi_lvl & hi_allow_q)
                 | lo_lvl;

  //////////////////////////////////////////////////////////////////////
  // Mode sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: begin
        if (shutdown_q) begin
          state_d = ST_PDOWN;
        end else if (wait_interrupt_instruction) begin
          state_d = deep_req_q ? ST_DEEP : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (irq_any) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_DEEP: begin
        if (wake_deep) begin
          state_d = ST_WAKE_OSC;
        end
      end
      ST_PDOWN: begin
        if (wake_pd) begin
          state_d = ST_WAKE_OSC;
        end
      end
      ST_WAKE_OSC: begin
        // Regulator and fast oscillator settle first
        if (osc_cnt_q == `PM_OSC_CNT_W'(`PM_OSC_START_CYC - 1)) begin
          state_d = ST_WAKE_REL;
        end
      end
      ST_WAKE_REL: begin
        state_d = ST_ACTIVE;
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // Oscillator settle counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_q <= '0;
    end else if (state_q == ST_WAKE_OSC) begin
      osc_cnt_q <= osc_cnt_q + 1'b1;
    end else begin
      osc_cnt_q <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sticky wake causes; a new cause beats a clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cause_q <= 3'h0;
    end else begin
      cause_q <= (reg_wen && reg_addr == `PM_OFS_STAT)
               ? cause_q & ~reg_wdata[`PM_SB_CAUSE +: 3] : cause_q;
      if (state_q == ST_DEEP && wake_deep) begin
        cause_q <= cause_q | {cnt_done, lo_lvl & lo_allow_q,
                              hi_lvl & hi_allow_q};
      end else if (state_q == ST_PDOWN && wake_pd) begin
        cause_q <= cause_q | {1'b0, lo_lvl, hi_lvl & hi_allow_q};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Supply, clock and CPU outputs follow the next state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core_regulator_on <= 1'b1;
      slow_osc_on <= 1'b1;
      fast_osc_on <= 1'b1;
      cpu_rst_n <= 1'b1;
      cpu_idle <= 1'b0;
      seq_run_en <= 1'b1;
      mode <= MODE_ACTIVE;
    end else begin
      core_regulator_on <= (state_d != ST_PDOWN);
      slow_osc_on <= (state_d != ST_PDOWN);
      fast_osc_on <= (state_d != ST_PDOWN) && (state_d != ST_DEEP);
      cpu_rst_n <= (state_d == ST_ACTIVE) || (state_d == ST_SLEEP);
      cpu_idle <= (state_d == ST_SLEEP);
      seq_run_en <= (state_d == ST_ACTIVE) || (state_d == ST_SLEEP);
      case (state_d)
        ST_SLEEP: mode <= MODE_SLEEP;
        ST_DEEP: mode <= MODE_DEEP;
        ST_PDOWN: mode <= MODE_PDOWN;
        default: mode <= MODE_ACTIVE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read zero
  always_comb begin
    rd_val = '0;
    if (rdec[3]) begin
      rd_val[1:0] = pbits[2*rdec[2:0] +: 2];
    end else begin
      case (reg_addr)
        `PM_OFS_SLEEP_CNT: rd_val[`PM_SLEEP_CNT_W-1:0] = sleep_start_q;
        `PM_OFS_CTRL: begin
          rd_val[`PM_CB_SHUTDOWN] = shutdown_q;
          rd_val[`PM_CB_DEEP] = deep_req_q;
          rd_val[`PM_CB_HI_ALLOW] = hi_allow_q;
          rd_val[`PM_CB_LO_ALLOW] = lo_allow_q;
        end
        `PM_OFS_STAT: begin
          rd_val[`PM_SB_MODE +: 2] = mode;
          rd_val[`PM_SB_CAUSE +: 3] = cause_q;
        end
        default: rd_val = '0;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : '0;
    end
  end

endmodule // power_mode_ctrl
`default_nettype wire

// [core/wake_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous wake pins.
// Assumes: One lane per pin; first stage read only by second.
// Notes:   Reset value per lane keeps pins inactive after reset.
`timescale 1ns/10ps
`default_nettype none
module wake_sync #(
  parameter int unsigned W = 2,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pins and synchronised levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q; // First stage only

  //////////////////////////////////////////////////////////////////////
  // One pair of flops per lane
  for (genvar i = 0; i < W; i++) begin : g_lane
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        meta_q[i] <= RST[i];
        dout[i] <= RST[i];
      end else begin
        meta_q[i] <= din[i];
        dout[i] <= meta_q[i];
      end
    end
  end

endmodule // wake_sync
`default_nettype wire

// [verif/fw_pins_model.sv]
// Purpose: Firmware events and external wake pins facing the block.
// Assumes: Tasks are called from the bench; one call at a time.
// Notes:   Pins idle inactive: high pin low, low pin high.
`timescale 1ns/10ps
`default_nettype none
module fw_pins_model (
  // Clock and CPU state
  input wire logic mclk,
  input wire logic cpu_rst_n,
  // Events toward the controller
  output logic wait_interrupt_instruction,
  output logic irq_any,
  output logic high_active_wake_pin,
  output logic low_active_wake_pin
);
  // Idle levels at time zero
  initial begin
    wait_interrupt_instruction = 1'b0;
    irq_any = 1'b0;
    high_active_wake_pin = 1'b0;
    low_active_wake_pin = 1'b1;
  end
  // Only running firmware can choose a new mode
  task automatic do_wait();
    if (cpu_rst_n === 1'b1) begin
      @(posedge mclk);
      wait_interrupt_instruction <= 1'b1;
      @(posedge mclk);
      wait_interrupt_instruction <= 1'b0;
    end
  endtask
  // Interrupt after a chosen lag, held two cycles
  task automatic raise_irq(input int lag);
    repeat (lag) @(posedge mclk);
    irq_any <= 1'b1;
    repeat (2) @(posedge mclk);
    irq_any <= 1'b0;
  endtask
  // Pin levels; asynchronous to the block
  task automatic set_pins(input logic hi, input logic lo);
    @(posedge mclk);
    high_active_wake_pin <= hi;
    low_active_wake_pin <= lo;
  endtask
endmodule // fw_pins_model
`default_nettype wire

// [verif/pm_checker.sv]
// Purpose: Port-level temporal checks for the power-mode controller.
// Assumes: Bound into power_mode_ctrl; a single mclk domain.
// Notes:   Wake release window follows the fixed oscillator settle.
`timescale 1ns/10ps
`include "pm_defines.svh"
`default_nettype none
module pm_checker #(
  parameter int unsigned SLOW_DIV = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Requests seen by the block
  input wire logic reg_wr,
  input wire logic wait_interrupt_instruction,
  input wire logic irq_any,
  input wire logic [`PM_NUM_PERIPH-1:0] periph_acc_req,
  // Controls driven by the block
  input wire logic core_regulator_on,
  input wire logic fast_osc_on,
  input wire logic slow_osc_on,
  input wire logic cpu_rst_n,
  input wire logic cpu_idle,
  input wire logic seq_run_en,
  input wire pm_pkg::pm_mode_t mode,
  input wire logic [`PM_NUM_PERIPH-1:0] periph_acc_ok,
  input wire logic [`PM_NUM_PERIPH-1:0] periph_clk_en,
  input wire logic [`PM_NUM_PERIPH-1:0] periph_rst_n
);
  import pm_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Cycles with fast oscillator up while the CPU is still held
  logic [15:0] wake_cnt_q;
  //////////////////////////////////////////////////////////////
  // Helper count; clears whenever the CPU runs or the osc is off
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cnt_q <= 16'h0000;
    end else if (fast_osc_on && !cpu_rst_n) begin
      wake_cnt_q <= wake_cnt_q + 16'h0001;
    end else begin
      wake_cnt_q <= 16'h0000;
    end
  end
  deep_supply_a: assert property (
    mode == MODE_DEEP |-> !fast_osc_on && slow_osc_on &&
      core_regulator_on && !cpu_rst_n) else $error("deep supplies wrong");
  pdown_supply_a: assert property (
    mode == MODE_PDOWN |-> !core_regulator_on && !fast_osc_on &&
      !slow_osc_on && !cpu_rst_n && periph_rst_n == '0)
    else $error("power down supplies wrong");
  seq_halt_a: assert property (
    (!fast_osc_on || mode == MODE_DEEP || mode == MODE_PDOWN) |->
      !seq_run_en) else $error("sequencer runs without fast osc");
  sleep_idle_a: assert property (
    mode == MODE_SLEEP |-> cpu_idle && fast_osc_on && cpu_rst_n &&
      core_regulator_on) else $error("sleep state outputs wrong");
  sleep_exit_a: assert property (
    mode == MODE_SLEEP && irq_any |=> mode == MODE_ACTIVE)
    else $error("interrupt did not end sleep");
  active_hold_a: assert property (
    mode == MODE_ACTIVE && cpu_rst_n && !wait_interrupt_instruction &&
      !reg_wr && !$past(reg_wr) |=> mode == MODE_ACTIVE)
    else $error("left active on its own");
  osc_gate_a: assert property (
    !$past(fast_osc_on) |-> periph_clk_en == '0)
    else $error("peripheral clock without fast osc");
  access_gate_a: assert property (
    (periph_acc_ok & ~($past(periph_acc_req) & periph_clk_en &
      periph_rst_n)) == '0) else $error("access passed while gated");
  wake_release_a: assert property (
    $rose(cpu_rst_n) |-> wake_cnt_q inside {[100:102]})
    else $error("CPU released before oscillator settled");
  // Main scenarios reached
  cover property (mode == MODE_SLEEP ##1 mode == MODE_ACTIVE);
  cover property (mode == MODE_DEEP);
  cover property (mode == MODE_PDOWN);
  cover property ($rose(cpu_rst_n));
endmodule // pm_checker

bind power_mode_ctrl pm_checker #(.SLOW_DIV(SLOW_DIV)) chk_u (
  .mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr),
  .wait_interrupt_instruction(wait_interrupt_instruction),
  .irq_any(irq_any), .periph_acc_req(periph_acc_req),
  .core_regulator_on(core_regulator_on), .fast_osc_on(fast_osc_on),
  .slow_osc_on(slow_osc_on), .cpu_rst_n(cpu_rst_n),
  .cpu_idle(cpu_idle), .seq_run_en(seq_run_en), .mode(mode),
  .periph_acc_ok(periph_acc_ok), .periph_clk_en(periph_clk_en),
  .periph_rst_n(periph_rst_n)
);
`default_nettype wire

// [verif/test_power_mode_and_clock_gating.sv]
// Purpose: Directed bench for modes, wake paths and peripheral gates.
// Assumes: Slow tick shortened to 8 mclk cycles.
// Notes:   Each scenario task judges its own results.
`timescale 1ns/10ps
`include "pm_defines.svh"
`default_nettype none
module test_power_mode_and_clock_gating;
  import pm_pkg::*;
  // Peripheral word offsets in index order
  localparam logic [7:0] OFS_TBL [6] = '{`PM_OFS_GPIO, `PM_OFS_I2CM,
    `PM_OFS_I2CS, `PM_OFS_UART, `PM_OFS_TMR, `PM_OFS_AFE};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] periph_acc_req = 6'h00;
  logic [31:0] reg_rdata;
  logic wait_w, irq_w, hi_pin, lo_pin, core_regulator_on, fast_osc_on;
  logic slow_osc_on, cpu_rst_n, cpu_idle, seq_run_en;
  pm_mode_t mode;
  logic [5:0] periph_acc_ok, periph_clk_en, periph_rst_n;
  int n_errors = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  //////////////////////////////////////////////////////////////
  power_mode_ctrl #(.SLOW_DIV(8)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wait_interrupt_instruction(wait_w),
    .irq_any(irq_w), .high_active_wake_pin(hi_pin),
    .low_active_wake_pin(lo_pin), .core_regulator_on(core_regulator_on),
    .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on),
    .cpu_rst_n(cpu_rst_n), .cpu_idle(cpu_idle), .seq_run_en(seq_run_en),
    .mode(mode), .periph_acc_req(periph_acc_req),
    .periph_acc_ok(periph_acc_ok), .periph_clk_en(periph_clk_en),
    .periph_rst_n(periph_rst_n));
  fw_pins_model fw_u (.mclk(mclk), .cpu_rst_n(cpu_rst_n),
    .wait_interrupt_instruction(wait_w), .irq_any(irq_w),
    .high_active_wake_pin(hi_pin), .low_active_wake_pin(lo_pin));
  //////////////////////////////////////////////////////////////
  // Comparisons
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: word %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input pm_mode_t got, input pm_mode_t exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: mode %h wanted %h", $time, got, exp);
    end
  endtask
  // Bus and timing helpers; sampling 1 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic acc(input int i, output logic [31:0] d);
    @(posedge mclk);
    periph_acc_req <= 6'h01 << i;
    @(posedge mclk);
    periph_acc_req <= 6'h00;
    #1 d = {26'h0, periph_acc_ok};
  endtask
  task automatic do_reset();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    tick(1);
  endtask
  // Bounded wait for the CPU to leave reset
  task automatic wait_run(input int lim);
    for (int k = 0; k < lim && cpu_rst_n !== 1'b1; k++) tick(1);
  endtask
  //////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    chk_mode(mode, MODE_ACTIVE);
    chk_word({26'h0, core_regulator_on, fast_osc_on, slow_osc_on,
      cpu_rst_n, cpu_idle, seq_run_en}, 32'h3d);
    chk_word({14'h0, periph_acc_ok, periph_clk_en, periph_rst_n}, 0);
    for (int i = 0; i < 6; i++) begin
      rd(OFS_TBL[i], d);
      chk_word(d, 32'h0);
    end
    rd(`PM_OFS_SLEEP_CNT, d);
    chk_word(d, 32'h0);
  endtask
  // Every block: refused, enabled, held in reset, clock off
  task automatic t_periph();
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      acc(i, d);
      chk_word(d, 32'h0);
      wr(OFS_TBL[i], 32'h3);
      rd(OFS_TBL[i], d);
      chk_word(d, 32'h3);
      chk_word({26'h0, periph_clk_en}, 32'h1 << i);
      acc(i, d);
      chk_word(d, 32'h1 << i);
      wr(OFS_TBL[i], 32'h2);
      acc(i, d);
      chk_word(d | {31'h0, periph_rst_n[i]}, 32'h0);
      wr(OFS_TBL[i], 32'h1);
      acc(i, d);
      chk_word(d | {26'h0, periph_clk_en}, 32'h0);
    end
    rd(8'h7c, d);
    chk_word(d, 32'h0);
  endtask
  task automatic t_sleep();
    wr(`PM_OFS_CTRL, 32'h0);
    fw_u.do_wait();
    tick(6);
    chk_mode(mode, MODE_SLEEP);
    chk_word({28'h0, cpu_idle, fast_osc_on, seq_run_en, cpu_rst_n},
      32'hf);
    fw_u.raise_irq(3);
    tick(1);
    chk_mode(mode, MODE_ACTIVE);
  endtask
  // Deep sleep entry, then one wake source or none
  task automatic t_deep(input logic [31:0] cnt, input logic [31:0] ctl,
      input logic hi, input logic lo, input logic woke,
      input logic [2:0] cause);
    logic [31:0] d;
    wr(`PM_OFS_SLEEP_CNT, cnt);
    wr(`PM_OFS_CTRL, ctl);
    fw_u.do_wait();
    tick(2);
    chk_mode(mode, MODE_DEEP);
    chk_word({28'h0, core_regulator_on, slow_osc_on, fast_osc_on | cpu_rst_n,
      seq_run_en}, 32'hc);
    fw_u.set_pins(hi, lo);
    wait_run(300);
    chk_word({31'h0, cpu_rst_n}, {31'h0, woke});
    fw_u.set_pins(1'b0, 1'b1);
    if (woke) begin
      chk_mode(mode, MODE_ACTIVE);
      rd(`PM_OFS_STAT, d);
      chk_word(d & 32'h73, {25'h0, cause, 4'h0});
      wr(`PM_OFS_STAT, 32'h70);
    end else begin
      do_reset();
    end
  endtask
  // Power down with a programmed block, woken by a pin
  task automatic t_pdown(input logic [31:0] ctl, input logic hi,
      input logic lo);
    logic [31:0] d;
    wr(`PM_OFS_AFE, 32'h3);
    wr(`PM_OFS_CTRL, ctl);
    tick(20);
    chk_mode(mode, MODE_PDOWN);
    chk_word({26'h0, core_regulator_on, fast_osc_on, slow_osc_on,
      cpu_rst_n, periph_rst_n[5], periph_clk_en[5]}, 32'h0);
    fw_u.set_pins(hi, lo);
    wait_run(300);
    fw_u.set_pins(1'b0, 1'b1);
    chk_word({31'h0, cpu_rst_n}, 32'h1);
    rd(`PM_OFS_AFE, d);
    chk_word(d, 32'h0);
    rd(`PM_OFS_CTRL, d);
    chk_word(d & 32'h3, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_reset();
    t_periph();
    t_sleep();
    t_deep(32'h0, 32'h2, 1'b1, 1'b0, 1'b0, 3'h0);
    t_deep(32'h3, 32'h2, 1'b0, 1'b1, 1'b1, 3'h4);
    t_deep(32'h0, 32'h6, 1'b1, 1'b1, 1'b1, 3'h1);
    t_deep(32'h0, 32'ha, 1'b0, 1'b0, 1'b1, 3'h2);
    t_pdown(32'h1, 1'b0, 1'b0);
    t_pdown(32'h5, 1'b1, 1'b1);
    final_report();
  end
  // Watchdog well beyond the expected run of about a thousand cycles
  initial begin
    #300000;
    n_errors++;
    final_report();
  end
endmodule // test_power_mode_and_clock_gating
`default_nettype wire
